// *** design/coc_comparator_output_control.sv ***
/*
  coc_comparator_output_control: 8-bit comparator output control register
  on an AXI4-Lite slave, with per-channel polarity, pin gating, timer
  trigger gating, interrupt flags with mask, and the speed selection.
  Assumes comparator results synchronous to SYS_CLK and one write and one
  read at most outstanding on the bus.
*/
// Notes on behaviour
// - control register readable, writable, resets to zero
// - bit 7 selects low or high speed
// - bit 6 inverts channel 1 pin level
// - bit 5 gates channel 1 pin output
// - bit 4 lets channel 1 requests flag
// - bit 2 inverts channel 0 pin level
// - bit 1 gates channel 0 pin output
// - bit 0 lets channel 0 requests flag
// - enabling channel 1 requests may set flag 1
// - enabling channel 0 requests may set flag 0
`timescale 1ns/10ps
module coc_comparator_output_control #(
  parameter int unsigned ADDR_W = 24
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic CH0_COMPARATOR_RESULT,
  input wire logic CH1_COMPARATOR_RESULT,
  output logic COMPARATOR_SPEED_SELECT,
  output logic CH0_OUTPUT_PIN,
  output logic CH0_OUTPUT_PIN_OE_B,
  output logic CH1_OUTPUT_PIN,
  output logic CH1_OUTPUT_PIN_OE_B,
  output logic CH0_TIMER_TRIGGER,
  output logic CH1_TIMER_TRIGGER,
  output logic IRQ
);

  // address match on the word index
  function automatic logic reg_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [coc_pkg::INDEX_W-1:0] idx
  );
    reg_hit = (addr[ADDR_W-1:2] == idx);
  endfunction : reg_hit

  coc_pkg::coc_ctrl_t ctrl_q;
  coc_pkg::coc_pins_t pins_q;
  logic [1:0] stat_q, mask_q, prev_q, ie_prev_q, bresp_q, rresp_q, stat_d;
  logic [1:0] res_v, pol_v, oe_v, ie_v, out_v, set_ev;
  logic speed_q, irq_q, awready_q, wready_q, aw_have_q, w_have_q, wr_fire;
  logic bvalid_q, arready_q, rvalid_q;
  logic [31:0] rdata_q, wdata_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [3:0] wstrb_q;

  // bus outputs straight from flops
  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RRESP = rresp_q;
  assign S_AXI_RDATA = rdata_q;

  // block outputs straight from flops
  assign COMPARATOR_SPEED_SELECT = speed_q;
  assign CH0_OUTPUT_PIN = pins_q.level[0];
  assign CH1_OUTPUT_PIN = pins_q.level[1];
  assign CH0_OUTPUT_PIN_OE_B = pins_q.oe_b[0];
  assign CH1_OUTPUT_PIN_OE_B = pins_q.oe_b[1];
  assign CH0_TIMER_TRIGGER = pins_q.trig[0];
  assign CH1_TIMER_TRIGGER = pins_q.trig[1];
  assign IRQ = irq_q;

  // write performs once address and data are both held
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

  // write address channel: ready pulses one cycle per request
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
    end else begin
      awready_q <= S_AXI_AWVALID && !awready_q && !aw_have_q && !bvalid_q;
      if (S_AXI_AWVALID && awready_q) begin
        aw_have_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  // write data channel, taken independently of the address
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wready_q <= 1'b0;
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      wready_q <= S_AXI_WVALID && !wready_q && !w_have_q && !bvalid_q;
      if (S_AXI_WVALID && wready_q) begin
        w_have_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // write response, slverr for an unmapped word
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      bvalid_q <= 1'b0;
      bresp_q <= coc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      if (reg_hit(awaddr_q, coc_pkg::CTRL_IDX) ||
          reg_hit(awaddr_q, coc_pkg::STAT_IDX) ||
          reg_hit(awaddr_q, coc_pkg::MASK_IDX)) begin
        bresp_q <= coc_pkg::RESP_OKAY;
      end else begin
        bresp_q <= coc_pkg::RESP_SLVERR;
      end
    end else if (S_AXI_BREADY && bvalid_q) begin
      bvalid_q <= 1'b0;
    end
  end

  // control register, bit 3 held at zero
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q <= coc_pkg::CTRL_RST;
    end else if (wr_fire && wstrb_q[0] &&
                 reg_hit(awaddr_q, coc_pkg::CTRL_IDX)) begin
      ctrl_q <= wdata_q[7:0] & coc_pkg::CTRL_WMASK;
    end
  end

  // interrupt mask register
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mask_q <= coc_pkg::MASK_RST;
    end else if (wr_fire && wstrb_q[0] &&
                 reg_hit(awaddr_q, coc_pkg::MASK_IDX)) begin
      mask_q <= wdata_q[1:0];
    end
  end

  // read channel, data answered one cycle after the address is taken
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= coc_pkg::RESP_OKAY;
      rdata_q <= '0;
    end else begin
      arready_q <= S_AXI_ARVALID && !arready_q && !rvalid_q;
      if (S_AXI_ARVALID && arready_q) begin
        rvalid_q <= 1'b1;
        rresp_q <= coc_pkg::RESP_OKAY;
        if (reg_hit(S_AXI_ARADDR, coc_pkg::CTRL_IDX)) begin
          rdata_q <= {24'h000000, ctrl_q};
        end else if (reg_hit(S_AXI_ARADDR, coc_pkg::STAT_IDX)) begin
          rdata_q <= {30'h0, stat_q};
        end else if (reg_hit(S_AXI_ARADDR, coc_pkg::MASK_IDX)) begin
          rdata_q <= {30'h0, mask_q};
        end else begin
          rdata_q <= 32'h00000000;
          rresp_q <= coc_pkg::RESP_SLVERR;
        end
      end else if (S_AXI_RREADY && rvalid_q) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // channel vectors, index 1 is channel 1
  assign res_v = {CH1_COMPARATOR_RESULT, CH0_COMPARATOR_RESULT};
  assign pol_v = {ctrl_q.ch1_pol, ctrl_q.ch0_pol};
  assign oe_v = {ctrl_q.ch1_oe, ctrl_q.ch0_oe};
  assign ie_v = {ctrl_q.ch1_ie, ctrl_q.ch0_ie};

  // per-channel polarity and request events
  generate
    for (genvar gi = 0; gi < 2; gi++) begin : g_ch
      // polarity applied to the comparator result
      assign out_v[gi] = res_v[gi] ^ pol_v[gi];
      // rising output while enabled, or enable rising while output high
      assign set_ev[gi] = ie_v[gi] &&
        ((out_v[gi] && !prev_q[gi]) ||
         (out_v[gi] && !ie_prev_q[gi]));
    end
  endgenerate

  // pin level, pin enable and timer trigger, all gated by pin enable
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pins_q.level <= 2'h0;
      pins_q.oe_b <= 2'h3;
      pins_q.trig <= 2'h0;
    end else begin
      pins_q.level <= out_v & oe_v;
      pins_q.oe_b <= ~oe_v;
      pins_q.trig <= out_v & oe_v;
    end
  end

  // speed selection; comparators are stopped by software beforehand
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      speed_q <= 1'b0;
    end else begin
      speed_q <= ctrl_q.speed;
    end
  end

  // edge history of outputs and enables
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      prev_q <= 2'h0;
      ie_prev_q <= 2'h0;
    end else begin
      prev_q <= out_v;
      ie_prev_q <= ie_v;
    end
  end

  // sticky flags: write one clears, a new event wins over the clear
  always_comb begin
    stat_d = stat_q;
    if (wr_fire && wstrb_q[0] && reg_hit(awaddr_q, coc_pkg::STAT_IDX)) begin
      stat_d = stat_q & ~wdata_q[1:0];
    end
    stat_d = stat_d | set_ev;
  end

  // flag register and masked interrupt level
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      stat_q <= coc_pkg::STAT_RST;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q <= |(stat_q & mask_q);
    end
  end

  // checks
  property p_ctrl_reset;
    @(posedge SYS_CLK) disable iff (!RST_B)
      !$past(RST_B) |-> (ctrl_q == coc_pkg::CTRL_RST && !speed_q);
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset)
    else $error("control register not zero after reset");
  property p_speed;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (wr_fire && wstrb_q[0] && reg_hit(awaddr_q, coc_pkg::CTRL_IDX))
      |-> ##2 (speed_q == $past(wdata_q[7], 2));
  endproperty
  a_speed: assert property (p_speed)
    else $error("speed output does not follow written bit 7");
  property p_ch1_level;
    @(posedge SYS_CLK) disable iff (!RST_B)
      ctrl_q.ch1_oe |=> (CH1_OUTPUT_PIN ==
        ($past(CH1_COMPARATOR_RESULT) ^ $past(ctrl_q.ch1_pol)));
  endproperty
  a_ch1_level: assert property (p_ch1_level)
    else $error("channel 1 pin level wrong for polarity");
  property p_ch1_gate;
    @(posedge SYS_CLK) disable iff (!RST_B)
      !ctrl_q.ch1_oe |=> (CH1_OUTPUT_PIN_OE_B && !CH1_OUTPUT_PIN &&
        !CH1_TIMER_TRIGGER);
  endproperty
  a_ch1_gate: assert property (p_ch1_gate)
    else $error("channel 1 drives while disabled");
  property p_ch1_ie;
    @(posedge SYS_CLK) disable iff (!RST_B)
      $rose(stat_q[1]) |-> $past(ctrl_q.ch1_ie);
  endproperty
  a_ch1_ie: assert property (p_ch1_ie)
    else $error("channel 1 flag set while requests blocked");
  property p_ch0_level;
    @(posedge SYS_CLK) disable iff (!RST_B)
      ctrl_q.ch0_oe |=> (CH0_OUTPUT_PIN ==
        ($past(CH0_COMPARATOR_RESULT) ^ $past(ctrl_q.ch0_pol)));
  endproperty
  a_ch0_level: assert property (p_ch0_level)
    else $error("channel 0 pin level wrong for polarity");
  property p_ch0_gate;
    @(posedge SYS_CLK) disable iff (!RST_B)
      ctrl_q.ch0_oe |=> (!CH0_OUTPUT_PIN_OE_B &&
        CH0_TIMER_TRIGGER == CH0_OUTPUT_PIN);
  endproperty
  a_ch0_gate: assert property (p_ch0_gate)
    else $error("channel 0 not driven while enabled");
  property p_ch0_ie;
    @(posedge SYS_CLK) disable iff (!RST_B)
      $rose(stat_q[0]) |-> $past(ctrl_q.ch0_ie);
  endproperty
  a_ch0_ie: assert property (p_ch0_ie)
    else $error("channel 0 flag set while requests blocked");
  property p_ch1_enable_flag;
    @(posedge SYS_CLK) disable iff (!RST_B)
      ($rose(ctrl_q.ch1_ie) && out_v[1]) |=> stat_q[1];
  endproperty
  a_ch1_enable_flag: assert property (p_ch1_enable_flag)
    else $error("channel 1 enable edge did not set flag");
  property p_ch0_enable_flag;
    @(posedge SYS_CLK) disable iff (!RST_B)
      ($rose(ctrl_q.ch0_ie) && out_v[0]) |=> stat_q[0];
  endproperty
  a_ch0_enable_flag: assert property (p_ch0_enable_flag)
    else $error("channel 0 enable edge did not set flag");
  property p_trigger;
    @(posedge SYS_CLK) disable iff (!RST_B)
      $rose(CH1_TIMER_TRIGGER) |-> $past(ctrl_q.ch1_oe);
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("timer trigger without pin enable");

  property p_rsvd;
    @(posedge SYS_CLK) disable iff (!RST_B)
      ctrl_q.rsvd == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("unused bit 3 is set");

  property p_irq;
    @(posedge SYS_CLK) disable iff (!RST_B)
      (stat_q[0] && mask_q[0]) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked flag did not raise interrupt");

  c_write: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    wr_fire ##[1:4] (S_AXI_BVALID && S_AXI_BREADY));
  c_read: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    (S_AXI_ARVALID && arready_q) ##1 S_AXI_RVALID);
  c_irq: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    $rose(IRQ));
  c_trig: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    $rose(CH0_TIMER_TRIGGER));
endmodule : coc_comparator_output_control

// *** pkg/coc_pkg.sv ***
/*
  coc_pkg: register map, field layout, reset values and bus codes of the
  comparator output control block.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package coc_pkg;

  // register indices; byte address is four times the index
  localparam int unsigned INDEX_W = 22;
  localparam logic [INDEX_W-1:0] CTRL_IDX = 22'h0f0342;
  localparam logic [INDEX_W-1:0] STAT_IDX = 22'h0f0343;
  localparam logic [INDEX_W-1:0] MASK_IDX = 22'h0f0344;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] STAT_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;

  // writable bits of the control register (bit 3 unused)
  localparam int unsigned RSVD_POS = 3;
  localparam logic [7:0] CTRL_WMASK = 8'hf7;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register layout, msb first
  typedef struct packed {
    logic speed;
    logic ch1_pol;
    logic ch1_oe;
    logic ch1_ie;
    logic rsvd;
    logic ch0_pol;
    logic ch0_oe;
    logic ch0_ie;
  } coc_ctrl_t;

  // per-channel pin drive
  typedef struct packed {
    logic [1:0] level;
    logic [1:0] oe_b;
    logic [1:0] trig;
  } coc_pins_t;

endpackage : coc_pkg

// *** sim/test_comparator_output_control.sv ***
/*
  test_comparator_output_control: self-checking bench for the comparator
  output control block; drives its AXI4-Lite port and comparator inputs.
  Assumes the bus timing and flag behaviour of the designer's hand-over.
*/
`timescale 1ns/10ps
module test_comparator_output_control;
  localparam logic [23:0] A_CTRL = {coc_pkg::CTRL_IDX, 2'b00};
  localparam logic [23:0] A_STAT = {coc_pkg::STAT_IDX, 2'b00};
  localparam logic [23:0] A_MASK = {coc_pkg::MASK_IDX, 2'b00};
  localparam logic [23:0] A_BAD = 24'h000010;
  localparam logic [1:0] OK = coc_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = coc_pkg::RESP_SLVERR;
  logic sys_clk = 1'b0;
  logic rst_b, awvalid, wvalid, bready, arvalid, rready, res0, res1;
  logic [23:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, speed, irq;
  logic pin0, oeb0, pin1, oeb1, trg0, trg1;
  logic [1:0] bresp, rresp;
  logic [7:0] c;
  int num_errors = 0;
  int tests_run = 0;
  logic [1:0] wq[$];
  logic [33:0] rq[$];

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  coc_comparator_output_control #(.ADDR_W(24)) dut_u (
    .SYS_CLK(sys_clk), .RST_B(rst_b),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CH0_COMPARATOR_RESULT(res0), .CH1_COMPARATOR_RESULT(res1),
    .COMPARATOR_SPEED_SELECT(speed), .CH0_OUTPUT_PIN(pin0),
    .CH0_OUTPUT_PIN_OE_B(oeb0), .CH1_OUTPUT_PIN(pin1),
    .CH1_OUTPUT_PIN_OE_B(oeb1), .CH0_TIMER_TRIGGER(trg0),
    .CH1_TIMER_TRIGGER(trg1), .IRQ(irq)
  );

  // verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task automatic give_up;
    num_errors++;
    $display("[FAIL] handshake expected answer seen none");
    final_report();
  endtask : give_up

  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_pin(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_pin

  // address and data offered together, each dropped when taken
  task automatic axi_write(input logic [23:0] a, input logic [31:0] d,
                           input logic [1:0] er);
    logic aw_p;
    logic w_p;
    int n;
    wq.push_back(er);
    aw_p = 1'b1;
    w_p = 1'b1;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while ((aw_p || w_p) && n < 40) begin
      @(posedge sys_clk);
      n++;
      if (awready === 1'b1) aw_p = 1'b0;
      if (wready === 1'b1) w_p = 1'b0;
      awvalid <= aw_p;
      wvalid <= w_p;
    end
    while (bvalid !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 40) give_up();
  endtask : axi_write

  task automatic axi_read(input logic [23:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
    int n;
    rq.push_back({er, ed});
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge sys_clk);
    while (arready !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 40) give_up();
  endtask : axi_read

  // pin, enable, trigger and speed after settling
  task automatic chk_pins(input logic [7:0] k, input logic r0,
                          input logic r1);
    repeat (3) @(posedge sys_clk);
    chk_pin("pin0", (r0 ^ k[2]) & k[1], pin0);
    chk_pin("oe0_b", ~k[1], oeb0);
    chk_pin("trig0", (r0 ^ k[2]) & k[1], trg0);
    chk_pin("pin1", (r1 ^ k[6]) & k[5], pin1);
    chk_pin("oe1_b", ~k[5], oeb1);
    chk_pin("trig1", (r1 ^ k[6]) & k[5], trg1);
    chk_pin("speed", k[7], speed);
  endtask : chk_pins

  task automatic chk_irq(input logic e);
    repeat (3) @(posedge sys_clk);
    chk_pin("irq", e, irq);
  endtask : chk_irq

  // pairs each bus answer with the oldest noted expectation
  always @(posedge sys_clk) begin : monitor
    logic [33:0] r;
    if (bvalid === 1'b1 && bready === 1'b1 && wq.size() > 0) begin
      chk_word("bresp", {30'h0, wq.pop_front()}, {30'h0, bresp});
    end
    if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0) begin
      r = rq.pop_front();
      chk_word("rdata", r[31:0], rdata);
      chk_word("rresp", {30'h0, r[33:32]}, {30'h0, rresp});
    end
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    $display("[FAIL] run expected finished seen running");
    final_report();
  end

  initial begin
    rst_b = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, res0, res1} = 7'h00;
    awaddr = 24'h0;
    araddr = 24'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    void'($urandom(32'hbd5a));
    @(posedge sys_clk);
    // reset values
    chk_pins(8'h00, 1'b0, 1'b0);
    axi_read(A_CTRL, 32'h0, OK);
    axi_read(A_STAT, 32'h0, OK);
    axi_read(A_MASK, 32'h0, OK);
    // random readback, bit 3 written high but reads zero
    for (int i = 0; i < 8; i++) begin
      c = (8'($urandom) & 8'hee) | 8'h08;
      axi_write(A_CTRL, {24'h0, c}, OK);
      axi_read(A_CTRL, {24'h0, c & coc_pkg::CTRL_WMASK}, OK);
    end
    // every polarity, pin enable, speed and result combination
    for (int i = 0; i < 128; i++) begin
      c = {i[6], i[5], i[4], 2'b00, i[3], i[2], 1'b0};
      // comparators taken as stopped when speed changes
      if (i[1:0] == 2'b00) axi_write(A_CTRL, {24'h0, c}, OK);
      res0 <= i[0];
      res1 <= i[1];
      chk_pins(c, i[0], i[1]);
    end
    // interrupt events, blocking, masking and clearing
    res0 <= 1'b0;
    res1 <= 1'b0;
    axi_write(A_CTRL, 32'h01, OK);
    axi_write(A_STAT, 32'h3, OK);
    axi_write(A_MASK, 32'h3, OK);
    res0 <= 1'b1;
    res1 <= 1'b1;
    chk_irq(1'b1);
    axi_read(A_STAT, 32'h1, OK);
    axi_write(A_STAT, 32'h1, OK);
    axi_read(A_STAT, 32'h0, OK);
    chk_irq(1'b0);
    axi_write(A_CTRL, 32'h11, OK);
    axi_read(A_STAT, 32'h2, OK);
    axi_write(A_MASK, 32'h1, OK);
    chk_irq(1'b0);
    axi_write(A_MASK, 32'h3, OK);
    chk_irq(1'b1);
    axi_write(A_STAT, 32'h2, OK);
    chk_irq(1'b0);
    axi_write(A_CTRL, 32'h10, OK);
    axi_write(A_CTRL, 32'h11, OK);
    axi_read(A_STAT, 32'h1, OK);
    axi_write(A_STAT, 32'h1, OK);
    axi_read(A_STAT, 32'h0, OK);
    // write without byte 0 strobed is answered but ignored
    wstrb <= 4'h0;
    axi_write(A_CTRL, 32'hff, OK);
    wstrb <= 4'hf;
    // unmapped place answers an error and leaves control alone
    axi_write(A_BAD, 32'hff, ERR);
    axi_read(A_BAD, 32'h0, ERR);
    axi_read(A_CTRL, 32'h11, OK);
    // second reset in mid-run
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    axi_read(A_CTRL, 32'h0, OK);
    chk_pins(8'h00, 1'b1, 1'b1);
    repeat (2) @(posedge sys_clk);
    final_report();
  end
endmodule : test_comparator_output_control
